//--- pkg/timer_block_map.svh
`ifndef TIMER_BLOCK_MAP_SVH
`define TIMER_BLOCK_MAP_SVH
`define CH_STRIDE        8'h40
`define OFF_BLOCK_TRIG   8'hC0
`define OFF_BLOCK_ROUTE  8'hC4
`define OFF_CMD          6'h00
`define OFF_MODE         6'h04
`define OFF_CV           6'h10
`define OFF_RA           6'h14
`define OFF_RB           6'h18
`define OFF_RC           6'h1C
`define OFF_STATUS       6'h20
`define OFF_IEN          6'h24
`define OFF_IDIS         6'h28
`define OFF_IMASK        6'h2C
`define CMD_CLK_ON       0
`define CMD_CLK_OFF      1
`define CMD_SWTRIG       2
`define MODE_WAVE        15
`define DIV_2            11'd1
`define DIV_8            11'd7
`define DIV_32           11'd31
`define DIV_128          11'd127
`define DIV_1024         11'd1023
`endif

//--- pkg/timer_block_pkg.sv
package timer_block_pkg;
  // capture-mode view of the channel mode register
  typedef struct packed {
    logic [11:0] unused_hi;
    logic [1:0]  load_b_edge;
    logic [1:0]  load_a_edge;
    logic        wave_mode;
    logic        compare_c_trigger_enable;
    logic [2:0]  unused_mid;
    logic        trigger_source_select;
    logic [1:0]  trigger_edge_select;
    logic        disable_on_b_load;
    logic        stop_on_b_load;
    logic [1:0]  gate_select;
    logic        count_edge_invert;
    logic [2:0]  count_source_select;
  } chan_mode_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [31:0] wdata;
  } chan_bus_t;
endpackage

//--- verilog/edge_sync.sv
`include "timer_block_map.svh"
// three-stage synchroniser; a change counts when stages 1 and 2 differ
module edge_sync (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic d_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  logic [2:0] sync;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) sync <= 3'h0;
    else sync <= {sync[1:0], d_in};
  end
  // stage 0 is read only by stage 1
  assign level_out = sync[1];
  assign rise_out  = sync[1] & ~sync[2];
  assign fall_out  = ~sync[1] & sync[2];
endmodule // edge_sync

//--- verilog/timer_channel.sv
// Strobed register access is this design's own decision.
`include "timer_block_map.svh"
module timer_channel
  import timer_block_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire chan_bus_t   bus_in,
  input  wire logic        sync_trig_in,
  input  wire logic [2:0]  ext_lvl_in,
  input  wire logic [2:0]  ext_rise_in,
  input  wire logic [2:0]  ext_fall_in,
  input  wire logic        div_tick_in_2,
  input  wire logic [4:0]  div_ticks_in,
  input  wire logic        a_lvl_in,
  input  wire logic        a_rise_in,
  input  wire logic        a_fall_in,
  input  wire logic        b_rise_in,
  input  wire logic        b_fall_in,
  output logic [31:0]      rdata_out
);
  chan_mode_t  mode;
  logic [15:0] count, reg_a, reg_b, reg_c;
  logic        clk_on, a_done, b_ok, wave;
  logic [7:0]  imask;
  logic        tick, sel_rise, sel_fall, gate, ext_trig, cmp_hit;
  logic        load_a, load_b, trig, a_ev_r, a_ev_f;
  logic [2:0]  src;

  assign wave = mode.wave_mode;
  assign src  = mode.count_source_select;

  // clock source and edge choice
  always_comb begin
    sel_rise = 1'b0;
    sel_fall = 1'b0;
    unique case (src)
      3'h0, 3'h1, 3'h2, 3'h3, 3'h4: sel_rise = div_ticks_in[src];
      3'h5: begin sel_rise = ext_rise_in[0]; sel_fall = ext_fall_in[0]; end
      3'h6: begin sel_rise = ext_rise_in[1]; sel_fall = ext_fall_in[1]; end
      3'h7: begin sel_rise = ext_rise_in[2]; sel_fall = ext_fall_in[2]; end
    endcase
    // divided ticks have no falling edge; treat them the same either way
    if (src > 3'h4 && mode.count_edge_invert) sel_rise = sel_fall;
    gate = (mode.gate_select == 2'h0) ? 1'b1 : ext_lvl_in[mode.gate_select - 2'h1];
    tick = sel_rise & gate & clk_on;
  end

  // trigger sources
  always_comb begin
    a_ev_r = mode.trigger_source_select ? a_rise_in : b_rise_in;
    a_ev_f = mode.trigger_source_select ? a_fall_in : b_fall_in;
    ext_trig = !wave && ((mode.trigger_edge_select[0] && a_ev_r) ||
                         (mode.trigger_edge_select[1] && a_ev_f));
    cmp_hit = mode.compare_c_trigger_enable && (count == reg_c);
    trig = sync_trig_in || ext_trig || cmp_hit ||
           (bus_in.wr && bus_in.addr == `OFF_CMD && bus_in.wdata[`CMD_SWTRIG]);
    load_a = !wave && !a_done &&
             ((mode.load_a_edge[0] && a_rise_in) || (mode.load_a_edge[1] && a_fall_in));
    load_b = !wave && a_done && b_ok && !load_a &&
             ((mode.load_b_edge[0] && a_rise_in) || (mode.load_b_edge[1] && a_fall_in));
  end

  // counter
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) count <= 16'h0;
    else if (trig) count <= 16'h0;
    else if (bus_in.wr && bus_in.addr == `OFF_CV) count <= bus_in.wdata[15:0];
    else if (tick) count <= count + 16'h1;
  end

  // counter clock enable
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) clk_on <= 1'b0;
    else if (bus_in.wr && bus_in.addr == `OFF_CMD && bus_in.wdata[`CMD_CLK_OFF])
      clk_on <= 1'b0;
    else if (load_b && (mode.stop_on_b_load || mode.disable_on_b_load))
      clk_on <= 1'b0;
    else if (trig) clk_on <= 1'b1;
    else if (bus_in.wr && bus_in.addr == `OFF_CMD && bus_in.wdata[`CMD_CLK_ON])
      clk_on <= 1'b1;
  end

  // load sequencing: A then B then A
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      a_done <= 1'b0;
      b_ok   <= 1'b0;
    end else if (trig) begin
      a_done <= 1'b0;
      b_ok   <= 1'b0;
    end else if (load_a) begin
      a_done <= 1'b1;
      b_ok   <= 1'b1;
    end else if (load_b) begin
      a_done <= 1'b0;
      b_ok   <= 1'b0;
    end
  end

  // registers A, B, C and mode
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_a <= 16'h0;
      reg_b <= 16'h0;
      reg_c <= 16'h0;
      mode  <= '0;
    end else begin
      if (load_a) reg_a <= count;
      else if (wave && bus_in.wr && bus_in.addr == `OFF_RA)
        reg_a <= bus_in.wdata[15:0];
      if (load_b) reg_b <= count;
      else if (wave && bus_in.wr && bus_in.addr == `OFF_RB)
        reg_b <= bus_in.wdata[15:0];
      if (bus_in.wr && bus_in.addr == `OFF_RC) reg_c <= bus_in.wdata[15:0];
      if (bus_in.wr && bus_in.addr == `OFF_MODE) mode <= bus_in.wdata;
    end
  end

  // interrupt mask
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) imask <= 8'h0;
    else if (bus_in.wr && bus_in.addr == `OFF_IEN)
      imask <= imask | bus_in.wdata[7:0];
    else if (bus_in.wr && bus_in.addr == `OFF_IDIS)
      imask <= imask & ~bus_in.wdata[7:0];
  end

  // read mux, combinational; top registers it
  always_comb begin
    unique case (bus_in.addr)
      `OFF_MODE:   rdata_out = mode;
      `OFF_CV:     rdata_out = {16'h0, count};
      `OFF_RA:     rdata_out = {16'h0, reg_a};
      `OFF_RB:     rdata_out = {16'h0, reg_b};
      `OFF_RC:     rdata_out = {16'h0, reg_c};
      `OFF_STATUS: rdata_out = {14'h0, a_lvl_in, clk_on, 16'h0};
      `OFF_IMASK:  rdata_out = {24'h0, imask};
      default:     rdata_out = 32'h0;
    endcase
  end

  // divide-by-two source counts one per tick when nothing else touches the counter
  div2_count_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (src == 3'h0 && mode.gate_select == 2'h0 && clk_on && div_tick_in_2 && !trig &&
     !(bus_in.wr && bus_in.addr == `OFF_CV)) |=> count == $past(count) + 16'h1)
    else $error("divided tick not counted");
  clk_disable_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (bus_in.wr && bus_in.addr == `OFF_CMD && bus_in.wdata[`CMD_CLK_OFF]) |=> !clk_on)
    else $error("disable ignored");
  swtrig_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    trig |=> count == 16'h0) else $error("trigger missed");
  b_stop_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (load_b && mode.stop_on_b_load && !trig) |=> !clk_on) else $error("no stop");
  ra_ro_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (!wave && !load_a) |=> $stable(reg_a)) else $error("ra written");
  b_order_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    load_b |-> a_done) else $error("b before a");
  cmp_trig_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (cmp_hit && !bus_in.wr) |=> count == 16'h0) else $error("compare reset");
  mask_set_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (bus_in.wr && bus_in.addr == `OFF_IEN) |=>
    (imask & $past(bus_in.wdata[7:0])) == $past(bus_in.wdata[7:0])) else $error("mask set");
  load_a_c: cover property (@(posedge clk_in) load_a ##[1:50] load_b);
  trig_c:   cover property (@(posedge clk_in) ext_trig);
  cmp_c:    cover property (@(posedge clk_in) cmp_hit);
endmodule // timer_channel

//--- verilog/timer_block.sv
`include "timer_block_map.svh"
module timer_block
  import timer_block_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic [2:0]  ext_clock_pin_in,
  input  wire logic [2:0]  chan_io_a_in,
  input  wire logic [2:0]  chan_io_b_in,
  output logic [31:0]      rdata_out
);
  logic [5:0]  routing;
  logic [10:0] prescale;
  logic [4:0]  ticks;
  logic [2:0]  pin_l, pin_r, pin_f, a_l, a_r, a_f, b_l, b_r, b_f;
  logic [2:0]  xl, xr, xf;
  logic        sync_trig;
  logic [31:0] ch_rdata [3];
  logic [31:0] next_rdata;

  // synchronise every pin
  for (genvar i = 0; i < 3; i++) begin : g_sync
    edge_sync u_pin (.clk_in(clk_in), .rst_b_in(rst_b_in), .d_in(ext_clock_pin_in[i]),
      .level_out(pin_l[i]), .rise_out(pin_r[i]), .fall_out(pin_f[i]));
    edge_sync u_a (.clk_in(clk_in), .rst_b_in(rst_b_in), .d_in(chan_io_a_in[i]),
      .level_out(a_l[i]), .rise_out(a_r[i]), .fall_out(a_f[i]));
    edge_sync u_b (.clk_in(clk_in), .rst_b_in(rst_b_in), .d_in(chan_io_b_in[i]),
      .level_out(b_l[i]), .rise_out(b_r[i]), .fall_out(b_f[i]));
  end

  // routing of external clock lines; code 01 connects nothing
  always_comb begin
    unique case (routing[1:0])
      2'h0: begin xl[0] = pin_l[0]; xr[0] = pin_r[0]; xf[0] = pin_f[0]; end
      2'h1: begin xl[0] = 1'b0; xr[0] = 1'b0; xf[0] = 1'b0; end
      2'h2: begin xl[0] = a_l[1]; xr[0] = a_r[1]; xf[0] = a_f[1]; end
      2'h3: begin xl[0] = a_l[2]; xr[0] = a_r[2]; xf[0] = a_f[2]; end
    endcase
    unique case (routing[3:2])
      2'h0: begin xl[1] = pin_l[1]; xr[1] = pin_r[1]; xf[1] = pin_f[1]; end
      2'h1: begin xl[1] = 1'b0; xr[1] = 1'b0; xf[1] = 1'b0; end
      2'h2: begin xl[1] = a_l[0]; xr[1] = a_r[0]; xf[1] = a_f[0]; end
      2'h3: begin xl[1] = a_l[2]; xr[1] = a_r[2]; xf[1] = a_f[2]; end
    endcase
    unique case (routing[5:4])
      2'h0: begin xl[2] = pin_l[2]; xr[2] = pin_r[2]; xf[2] = pin_f[2]; end
      2'h1: begin xl[2] = 1'b0; xr[2] = 1'b0; xf[2] = 1'b0; end
      2'h2: begin xl[2] = a_l[0]; xr[2] = a_r[0]; xf[2] = a_f[0]; end
      2'h3: begin xl[2] = a_l[1]; xr[2] = a_r[1]; xf[2] = a_f[1]; end
    endcase
  end

  // shared prescaler; one tick per divided period
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) prescale <= 11'h0;
    else prescale <= prescale + 11'h1;
  end
  assign ticks = {((prescale & `DIV_1024) == `DIV_1024), ((prescale & `DIV_128) == `DIV_128),
                  ((prescale & `DIV_32) == `DIV_32), ((prescale & `DIV_8) == `DIV_8),
                  ((prescale & `DIV_2) == `DIV_2)};

  // routing register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) routing <= 6'h0;
    else if (wr_in && addr_in == `OFF_BLOCK_ROUTE) routing <= wdata_in[5:0];
  end

  assign sync_trig = wr_in && addr_in == `OFF_BLOCK_TRIG && wdata_in[0];

  // three channels at fixed strides
  for (genvar c = 0; c < 3; c++) begin : g_ch
    chan_bus_t cb;
    assign cb.wr    = wr_in && addr_in[7:6] == 2'(c);
    assign cb.rd    = rd_in && addr_in[7:6] == 2'(c);
    assign cb.addr  = addr_in[5:0];
    assign cb.wdata = wdata_in;
    timer_channel u_ch (.clk_in(clk_in), .rst_b_in(rst_b_in), .bus_in(cb),
      .sync_trig_in(sync_trig), .ext_lvl_in(xl), .ext_rise_in(xr), .ext_fall_in(xf),
      .div_tick_in_2(ticks[0]), .div_ticks_in(ticks), .a_lvl_in(a_l[c]),
      .a_rise_in(a_r[c]), .a_fall_in(a_f[c]), .b_rise_in(b_r[c]), .b_fall_in(b_f[c]),
      .rdata_out(ch_rdata[c]));
  end

  // registered read data, valid the cycle after the strobe
  always_comb begin
    next_rdata = 32'h0;
    if (rd_in) begin
      if (addr_in == `OFF_BLOCK_ROUTE) next_rdata = {26'h0, routing};
      else if (addr_in[7:6] != 2'h3) next_rdata = ch_rdata[addr_in[7:6]];
    end
  end
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) rdata_out <= 32'h0;
    else rdata_out <= next_rdata;
  end

  route_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    routing[1:0] == 2'h1 |-> !xl[0]) else $error("line 0 not idle");
  sync_c: cover property (@(posedge clk_in) sync_trig);
endmodule // timer_block

//--- dv/timer_pins.sv
// far side of the timer block: clock pins and channel A/B lines
module timer_pins (
  input  wire logic  clk_in,
  output logic [2:0] ext_clock_pin_out,
  output logic [2:0] chan_io_a_out,
  output logic [2:0] chan_io_b_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // every pin is a driven input of the device, so idle is a firm low
  initial begin
    ext_clock_pin_out = 3'h0;
    chan_io_a_out = 3'h0;
    chan_io_b_out = 3'h0;
  end
  // each level held 6 cycles so the 3-stage sync sees every edge
  task automatic drive(input int kind, input int idx, input logic v);
    @(posedge clk_in);
    case (kind)
      0: ext_clock_pin_out[idx] <= v;
      1: chan_io_a_out[idx] <= v;
      default: chan_io_b_out[idx] <= v;
    endcase
    repeat (5) @(posedge clk_in);
  endtask
endmodule // timer_pins

//--- dv/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in;
  logic        rst_b_in;
  logic [7:0]  addr_in;
  logic [31:0] wdata_in;
  logic        wr_in;
  logic        rd_in;
  logic [2:0]  ext_clock_pin_in;
  logic [2:0]  chan_io_a_in;
  logic [2:0]  chan_io_b_in;
  logic [31:0] rdata_out;
  logic [31:0] d;
  int          err_total;
  int          tests_run;
  int          alt [3][2] = '{'{1, 2}, '{0, 2}, '{0, 1}};
  logic [7:0]  offs [8] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h2C};

  timer_block uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .ext_clock_pin_in(ext_clock_pin_in), .chan_io_a_in(chan_io_a_in),
    .chan_io_b_in(chan_io_b_in), .rdata_out(rdata_out));
  timer_pins pins (.clk_in(clk_in), .ext_clock_pin_out(ext_clock_pin_in),
    .chan_io_a_out(chan_io_a_in), .chan_io_b_out(chan_io_b_in));

  // 250 MHz master clock
  always #2 clk_in = ~clk_in;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one-cycle strobes; a gap cycle follows so strobes never overlap
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    v = rdata_out;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    check($sformatf("reg %h", a), v, exp);
  endtask

  task automatic pulse(input int kind, input int idx, input int n);
    repeat (n) begin
      pins.drive(kind, idx, 1'b1);
      pins.drive(kind, idx, 1'b0);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // whole run is under a thousand cycles; 25000 cycles means a hang
  initial begin
    #100000;
    err_total++;
    stop_test();
  end

  initial begin
    clk_in = 1'b0;
    rst_b_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 32'h0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    err_total = 0;
    tests_run = 0;
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    // reset values, write-only and reserved places read zero
    for (int ch = 0; ch < 3; ch++) begin
      foreach (offs[i])
        rchk(8'(ch * 64) + offs[i], 32'h0);
      wr(8'(ch * 64) + 8'h1C, 32'h1230 + 32'(ch));
    end
    rchk(8'hC4, 32'h0);
    for (int ch = 0; ch < 3; ch++)
      rchk(8'(ch * 64) + 8'h1C, 32'h1230 + 32'(ch));
    // interrupt mask set and clear
    wr(8'h24, 32'h05);
    wr(8'h24, 32'h0A);
    rchk(8'h2C, 32'h0F);
    wr(8'h28, 32'h04);
    rchk(8'h2C, 32'h0B);
    // capture on line 0: A loads on rise, B on fall
    wr(8'h04, 32'h0009_0005);
    wr(8'h00, 32'h5);
    pulse(0, 0, 3);
    rchk(8'h10, 32'h3);
    pins.drive(1, 0, 1'b1);
    rchk(8'h14, 32'h3);
    pulse(0, 0, 2);
    pins.drive(1, 0, 1'b0);
    rchk(8'h18, 32'h5);
    wr(8'h14, 32'hFFFF);
    rchk(8'h14, 32'h3);
    pins.drive(1, 0, 1'b1);
    rchk(8'h14, 32'h5);
    pulse(0, 0, 1);
    pins.drive(1, 0, 1'b0);
    rchk(8'h18, 32'h6);
    // after a trigger B must wait for a fresh A load
    pins.drive(1, 0, 1'b1);
    wr(8'h00, 32'h4);
    rchk(8'h10, 32'h0);
    pulse(0, 0, 2);
    pins.drive(1, 0, 1'b0);
    rchk(8'h18, 32'h6);
    pins.drive(1, 0, 1'b1);
    rchk(8'h14, 32'h2);
    // disable wins over enable in one write
    wr(8'h00, 32'h3);
    pulse(0, 0, 2);
    rchk(8'h10, 32'h2);
    wr(8'h00, 32'h1);
    pulse(0, 0, 1);
    rchk(8'h10, 32'h3);
    wr(8'hC0, 32'h0);
    rchk(8'h10, 32'h3);
    wr(8'hC0, 32'h1);
    rchk(8'h10, 32'h0);
    // a fresh A then B load with stop or disable set halts the count
    wr(8'h04, 32'h0009_0045);
    pins.drive(1, 0, 1'b0);
    pulse(1, 0, 1);
    pulse(0, 0, 2);
    rchk(8'h10, 32'h0);
    rd(8'h20, d);
    check("clock enabled", 32'(d[16]), 32'h0);
    wr(8'h04, 32'h0009_0085);
    wr(8'h00, 32'h4);
    pulse(1, 0, 1);
    rd(8'h20, d);
    check("clock enabled", 32'(d[16]), 32'h0);
    // invert: count on the falling edge only
    wr(8'h04, 32'h0000_000D);
    wr(8'h00, 32'h5);
    pins.drive(0, 0, 1'b1);
    rchk(8'h10, 32'h0);
    pins.drive(0, 0, 1'b0);
    rchk(8'h10, 32'h1);
    // gating by line 1, then rising trigger on the B line
    wr(8'h04, 32'h0000_0025);
    pulse(0, 0, 2);
    rchk(8'h10, 32'h1);
    pins.drive(0, 1, 1'b1);
    pulse(0, 0, 2);
    rchk(8'h10, 32'h3);
    wr(8'h04, 32'h0000_0125);
    pins.drive(2, 0, 1'b1);
    rchk(8'h10, 32'h0);
    // falling trigger taken from the A line; its rise must not trigger
    pulse(0, 0, 1);
    wr(8'h04, 32'h0000_0625);
    pins.drive(1, 0, 1'b1);
    rchk(8'h10, 32'h1);
    pins.drive(1, 0, 1'b0);
    rchk(8'h10, 32'h0);
    pins.drive(0, 1, 1'b0);
    pins.drive(2, 0, 1'b0);
    // compare C match restarts the count; four edges leave one
    wr(8'h1C, 32'h3);
    wr(8'h04, 32'h0000_4005);
    wr(8'h00, 32'h5);
    pulse(0, 0, 4);
    rchk(8'h10, 32'h1);
    // waveform mode lets software write register A
    wr(8'h04, 32'h0000_8000);
    wr(8'h14, 32'h1234);
    rchk(8'h14, 32'h1234);
    // routing of each line: pin, none, then the two neighbour A lines
    for (int ln = 0; ln < 3; ln++) begin
      wr(8'(ln * 64) + 8'h04, 32'h5 + 32'(ln));
      wr(8'hC4, 32'h0);
      wr(8'(ln * 64), 32'h5);
      pulse(0, ln, 2);
      rchk(8'(ln * 64) + 8'h10, 32'h2);
      wr(8'hC4, 32'h1 << (2 * ln));
      pulse(0, ln, 2);
      rchk(8'(ln * 64) + 8'h10, 32'h2);
      wr(8'hC4, 32'h2 << (2 * ln));
      pulse(1, alt[ln][0], 2);
      rchk(8'(ln * 64) + 8'h10, 32'h4);
      wr(8'hC4, 32'h3 << (2 * ln));
      pulse(1, alt[ln][1], 2);
      rchk(8'(ln * 64) + 8'h10, 32'h6);
    end
    rchk(8'hC4, 32'h30);
    stop_test();
  end
endmodule // testbench
